// File: rtl/smc_pkg.sv
package smc_pkg;
  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] SMC_STANDBY_CLOCK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] SMC_TIME_BASE_CONTROL_OFS     = 8'h04;
  localparam logic [7:0] SMC_INT_CONTROL_OFS           = 8'h08;
  localparam logic [7:0] SMC_STATUS_OFS                = 8'h0c;
  // standby_clock_control fields
  localparam int SMC_XEN_BIT   = 7;
  localparam int SMC_XTEN_BIT  = 6;
  localparam int SMC_SYSCK_BIT = 5;
  localparam int SMC_HALT_BIT  = 4;
  localparam int SMC_TGH_BIT   = 2;
  // time_base_control fields
  localparam int SMC_TBEN_BIT  = 7;
  localparam int SMC_TBCK_LSB  = 0;
  // interrupt control fields
  localparam int SMC_MASTER_EN_BIT = 0;
  localparam int SMC_TB_IRQ_EN_BIT = 1;
  localparam int SMC_WD_PEND_BIT   = 2;
  localparam int SMC_IL6_BIT   = 3;
  localparam logic [7:0] SMC_SCC_RESET = 8'h80;
  localparam logic [7:0] SMC_TBC_RESET = 8'h00;
  localparam logic [1:0] SMC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'b10;
  // Program counter step past the entry instruction
  localparam logic [15:0] SMC_PC_STEP = 16'h0002;
  typedef enum logic [2:0] {
    SMC_RUN,
    SMC_SLOW,
    SMC_CPU_HALT,
    SMC_DEEP_HALT,
    SMC_WAKE
  } smc_state_type;
endpackage : smc_pkg

// File: rtl/smc_standby_mode_control.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - CPU-halt stops CPU and watchdog clocks; peripherals keep running.
// - Halt modes freeze CPU state, memory, PSW and port latches.
// - On halt entry the held PC is entry instruction address plus two.
// - Writing one to halt request bit enters CPU-halt; writing both halt bits at once enters neither mode.
// - CPU-halt release clears the halt bit and resumes prior run mode.
// - Reset pin low ends halt; execution restarts in high-clock-only run.
// - Master enable zero: enabled request wakes without vectoring, latch kept.
// - Master enable one: enabled request wakes and is serviced first.
// - Watchdog interrupt just before entry is serviced; halt not entered.
// - Deep-halt gates every peripheral clock except time base timer.
// - Writing one to timing generator halt bit enters deep-halt; with halt request bit also one, neither mode is entered.
// - Deep-halt release clears the bit and resumes prior run mode.
// - Time base enable set before deep-halt entry sets its interrupt latch.
// - Deep-halt entry and wake ignore the time base enable.
// - Deep-halt ends on selected time base clock falling edge.
// - All three enables one: wake edge also starts time base service.
// - Wake uses asynchronous clock; halt may be shorter than a period.
// - Both oscillators off, or selected oscillator off, raises a reset.
module smc_standby_mode_control
  import smc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic [15:0] entry_pc,
  input  wire logic        irq_request,
  input  wire logic        watchdog_irq,
  input  wire logic        low_clock_pin,
  input  wire logic [7:0]  tb_source_pins,
  output logic             cpu_clock_en,
  output logic             watchdog_clock_en,
  output logic             periph_clock_en,
  output logic             time_base_clock_en,
  output logic             cpu_state_hold,
  output logic [15:0]      held_pc,
  output logic             vector_request,
  output logic             time_base_vector,
  output logic             system_clock_reset,
  output logic             high_osc_enable,
  output logic             low_osc_enable,
  output logic             system_clock_select
);

  smc_state_type state_reg;
  smc_state_type run_mode_reg;
  logic [7:0]    scc_reg;
  logic [7:0]    tbc_reg;
  logic          master_en_reg;
  logic          tb_irq_en_reg;
  logic          il6_reg;
  logic          wd_pend_reg;
  logic          aw_hold_reg;
  logic          w_hold_reg;
  logic [7:0]    aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          bvalid_reg;
  logic [1:0]    bresp_reg;
  logic          rvalid_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    rresp_reg;
  logic [15:0]   held_pc_reg;
  logic          vec_reg;
  logic          tbvec_reg;
  logic          sys_rst_reg;
  logic [2:0]    lck_sync_reg;
  logic [2:0]    irq_sync_reg;
  logic [2:0]    tb_sync_reg;
  logic          lck_prev_reg;
  logic          wr_fire;
  logic          halt_set;
  logic          tgh_set;
  logic          lp_tick;
  logic          tb_level_reg;
  logic          tb_edge_q;
  logic          tb_src;
  logic          irq_woke;
  logic [7:0]    scc_next;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == SMC_STANDBY_CLOCK_CONTROL_OFS) || (a == SMC_TIME_BASE_CONTROL_OFS) ||
                 (a == SMC_INT_CONTROL_OFS) || (a == SMC_STATUS_OFS);
  endfunction : known_addr

  // AXI write channel: address and data captured in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= known_addr(aw_addr_reg) ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Read channel, one outstanding read
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= SMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= known_addr(s_axi_araddr) ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
      case (s_axi_araddr)
        SMC_STANDBY_CLOCK_CONTROL_OFS: rdata_reg <= {24'h000000, scc_reg};
        SMC_TIME_BASE_CONTROL_OFS:     rdata_reg <= {24'h000000, tbc_reg};
        SMC_INT_CONTROL_OFS:           rdata_reg <= {28'h0000000, il6_reg, wd_pend_reg, tb_irq_en_reg, master_en_reg};
        SMC_STATUS_OFS:                rdata_reg <= {13'h0000, 3'(state_reg), held_pc_reg};
        default:                       rdata_reg <= 32'h0000_0000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  assign tb_src = tb_source_pins[tbc_reg[SMC_TBCK_LSB +: 3]];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lck_sync_reg <= 3'h0;
      irq_sync_reg <= 3'h0;
      tb_sync_reg  <= 3'h0;
      lck_prev_reg <= 1'b0;
      tb_level_reg <= 1'b0;
    end else begin
      lck_sync_reg <= {lck_sync_reg[1:0], low_clock_pin};
      irq_sync_reg <= {irq_sync_reg[1:0], irq_request};
      tb_sync_reg  <= {tb_sync_reg[1:0], tb_src};
      if (lck_sync_reg[1] == lck_sync_reg[2]) begin
        lck_prev_reg <= lck_sync_reg[2];
      end
      if (tb_sync_reg[1] == tb_sync_reg[2]) begin
        tb_level_reg <= tb_sync_reg[2];
      end
    end
  end
  // CPU-halt wake requests are only looked at on the low-power clock tick; deep-halt wake waits on the time base edge instead
  assign lp_tick  = (lck_sync_reg[1] == lck_sync_reg[2]) && lck_sync_reg[2] && !lck_prev_reg;
  // Falling edge of the selected time base source; it may land early in its period
  assign tb_edge_q = tb_level_reg && (tb_sync_reg[1] == tb_sync_reg[2]) && !tb_sync_reg[2];
  assign irq_woke  = (irq_sync_reg[1] == irq_sync_reg[2]) && irq_sync_reg[2];

  // Write decode
  assign halt_set = wr_fire && w_strb_reg[0] && aw_addr_reg == SMC_STANDBY_CLOCK_CONTROL_OFS
                    && w_data_reg[SMC_HALT_BIT];
  assign tgh_set  = wr_fire && w_strb_reg[0] && aw_addr_reg == SMC_STANDBY_CLOCK_CONTROL_OFS
                    && w_data_reg[SMC_TGH_BIT];

  // Mode state machine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= SMC_RUN;
      run_mode_reg <= SMC_RUN;
      held_pc_reg  <= 16'h0000;
      vec_reg      <= 1'b0;
      tbvec_reg    <= 1'b0;
    end else begin
      vec_reg   <= 1'b0;
      tbvec_reg <= 1'b0;
      case (state_reg)
        SMC_RUN, SMC_SLOW: begin
          // A pending watchdog interrupt wins; the entry write is dropped
          if (wd_pend_reg || watchdog_irq) begin
            state_reg <= state_reg;
          end else if (halt_set && !tgh_set) begin
            run_mode_reg <= state_reg;
            state_reg    <= SMC_CPU_HALT;
            held_pc_reg  <= 16'(entry_pc + SMC_PC_STEP);
          end else if (tgh_set && !halt_set) begin
            run_mode_reg <= state_reg;
            state_reg    <= SMC_DEEP_HALT;
            held_pc_reg  <= 16'(entry_pc + SMC_PC_STEP);
          end else if (scc_reg[SMC_SYSCK_BIT]) begin
            state_reg <= SMC_SLOW;
          end else begin
            state_reg <= SMC_RUN;
          end
        end
        SMC_CPU_HALT: begin
          if (lp_tick && irq_woke) begin
            state_reg <= SMC_WAKE;
            vec_reg   <= master_en_reg;
          end
        end
        SMC_DEEP_HALT: begin
          if (tb_edge_q) begin
            state_reg <= SMC_WAKE;
            tbvec_reg <= master_en_reg && tb_irq_en_reg && tbc_reg[SMC_TBEN_BIT];
          end
        end
        SMC_WAKE: begin
          state_reg <= run_mode_reg;
        end
        default: state_reg <= SMC_RUN;
      endcase
    end
  end
  assign held_pc          = held_pc_reg;
  assign vector_request   = vec_reg;
  assign time_base_vector = tbvec_reg;

  // standby_clock_control; halt bits self-clear on release, software write sets
  always_comb begin
    scc_next = scc_reg;
    if (wr_fire && w_strb_reg[0] && aw_addr_reg == SMC_STANDBY_CLOCK_CONTROL_OFS) begin
      scc_next = w_data_reg[7:0] & 8'hf4;
    end
    if (state_reg == SMC_WAKE) begin
      scc_next[SMC_HALT_BIT] = 1'b0;
      scc_next[SMC_TGH_BIT]  = 1'b0;
    end
    if ((state_reg == SMC_RUN || state_reg == SMC_SLOW) && (wd_pend_reg || watchdog_irq)) begin
      scc_next[SMC_HALT_BIT] = 1'b0;
      scc_next[SMC_TGH_BIT]  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scc_reg     <= SMC_SCC_RESET;
      tbc_reg     <= SMC_TBC_RESET;
      sys_rst_reg <= 1'b0;
    end else begin
      scc_reg <= scc_next;
      if (wr_fire && w_strb_reg[0] && aw_addr_reg == SMC_TIME_BASE_CONTROL_OFS) begin
        tbc_reg <= w_data_reg[7:0];
      end
      sys_rst_reg <= (!scc_next[SMC_XEN_BIT] && !scc_next[SMC_XTEN_BIT])
                     || (!scc_next[SMC_SYSCK_BIT] && !scc_next[SMC_XEN_BIT])
                     || (scc_next[SMC_SYSCK_BIT] && !scc_next[SMC_XTEN_BIT]);
    end
  end

  // Interrupt flags; hardware set wins over a software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_en_reg <= 1'b0;
      tb_irq_en_reg <= 1'b0;
      il6_reg       <= 1'b0;
      wd_pend_reg   <= 1'b0;
    end else begin
      if (wr_fire && w_strb_reg[0] && aw_addr_reg == SMC_INT_CONTROL_OFS) begin
        master_en_reg <= w_data_reg[SMC_MASTER_EN_BIT];
        tb_irq_en_reg <= w_data_reg[SMC_TB_IRQ_EN_BIT];
        il6_reg       <= w_data_reg[SMC_IL6_BIT];
        wd_pend_reg   <= w_data_reg[SMC_WD_PEND_BIT];
      end
      if (watchdog_irq) begin
        wd_pend_reg <= 1'b1;
      end
      if (tgh_set && tbc_reg[SMC_TBEN_BIT] && state_reg != SMC_CPU_HALT && state_reg != SMC_DEEP_HALT) begin
        il6_reg <= 1'b1;
      end
    end
  end

  // Clock gating
  assign cpu_clock_en       = state_reg != SMC_CPU_HALT && state_reg != SMC_DEEP_HALT;
  assign watchdog_clock_en  = cpu_clock_en;
  assign periph_clock_en    = state_reg != SMC_DEEP_HALT;
  assign time_base_clock_en = 1'b1;
  assign cpu_state_hold     = !cpu_clock_en;
  assign system_clock_reset = sys_rst_reg;
  assign high_osc_enable    = scc_reg[SMC_XEN_BIT];
  assign low_osc_enable     = scc_reg[SMC_XTEN_BIT];
  assign system_clock_select = scc_reg[SMC_SYSCK_BIT];
  property p_halt_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    halt_set && !tgh_set && !wd_pend_reg && !watchdog_irq && state_reg == SMC_RUN
      |=> state_reg == SMC_CPU_HALT && held_pc == 16'($past(entry_pc) + SMC_PC_STEP);
  endproperty
  a_halt_pc: assert property (p_halt_pc) else $error("halt entry pc wrong");
  property p_cpu_clk;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == SMC_CPU_HALT |-> !cpu_clock_en && !watchdog_clock_en && periph_clock_en;
  endproperty
  a_cpu_clk: assert property (p_cpu_clk) else $error("cpu halt gating wrong");
  property p_deep_clk;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == SMC_DEEP_HALT |-> !periph_clock_en && time_base_clock_en;
  endproperty
  a_deep_clk: assert property (p_deep_clk) else $error("deep halt gating wrong");
  property p_wake_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == SMC_WAKE |=> !scc_reg[SMC_HALT_BIT] && !scc_reg[SMC_TGH_BIT] && state_reg == $past(run_mode_reg);
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("release did not clear");
  property p_wdt_block;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == SMC_RUN || state_reg == SMC_SLOW) && wd_pend_reg |=> state_reg != SMC_CPU_HALT && state_reg != SMC_DEEP_HALT;
  endproperty
  a_wdt_block: assert property (p_wdt_block) else $error("halt entered over watchdog");
  property p_tb_vec;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == SMC_DEEP_HALT && tb_edge_q
      |=> time_base_vector == $past(master_en_reg && tb_irq_en_reg && tbc_reg[SMC_TBEN_BIT]);
  endproperty
  a_tb_vec: assert property (p_tb_vec) else $error("time base vector wrong");
  property p_vec;
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == SMC_CPU_HALT && lp_tick && irq_woke
      |=> vector_request == $past(master_en_reg) ##1 state_reg != SMC_CPU_HALT;
  endproperty
  a_vec: assert property (p_vec) else $error("cpu halt wake wrong");
  property p_osc;
    @(posedge ref_clk) disable iff (!rst_n)
    !high_osc_enable && !low_osc_enable |-> system_clock_reset;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator reset missing");
  c_cpu:  cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == SMC_CPU_HALT ##[1:50] state_reg == SMC_WAKE);
  c_deep: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == SMC_DEEP_HALT ##[1:50] state_reg == SMC_WAKE);
  c_slow: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == SMC_SLOW);
endmodule : smc_standby_mode_control

// File: bench/smc_cpu_model.sv
`timescale 1ns/1ns
// Far side of the mode controller: the interrupt controller's request line
// and the free-running clock sources that the controller samples.
module smc_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       wake_cmd,
  output logic            irq_request,
  output logic            low_clock_pin,
  output logic [7:0]      tb_source_pins
);
  // Oscillators run free and are never reset, like the real crystals
  logic [10:0] div_reg = 11'h000;

  always_ff @(posedge ref_clk) begin
    div_reg <= div_reg + 11'h001;
  end

  // Low clock is already warmed up when the bench starts any scenario
  assign low_clock_pin  = div_reg[3];
  // Source k has a period of 16 << k cycles
  assign tb_source_pins = div_reg[10:3];

  // Request only for a source the bench has enabled; the controller still
  // treats it as a pin and passes it through its synchroniser
  always_ff @(posedge ref_clk) begin
    irq_request <= wake_cmd;
  end
endmodule : smc_cpu_model

// File: bench/smc_standby_mode_control_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module smc_standby_mode_control_tb_top;
  import smc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [15:0] entry_pc = 16'h0000;
  logic        watchdog_irq = 1'b0, wake_cmd = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        irq_request, low_clock_pin, cpu_clock_en, watchdog_clock_en, periph_clock_en;
  logic        time_base_clock_en, cpu_state_hold, vector_request, time_base_vector;
  logic        system_clock_reset, high_osc_enable, low_osc_enable, system_clock_select;
  logic [7:0]  tb_source_pins;
  logic [15:0] held_pc;
  int          error_cnt = 0, samples_checked = 0, vec_cnt = 0, tbv_cnt = 0;

  smc_standby_mode_control u_smc_standby_mode_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .entry_pc(entry_pc), .irq_request(irq_request), .watchdog_irq(watchdog_irq),
    .low_clock_pin(low_clock_pin), .tb_source_pins(tb_source_pins), .cpu_clock_en(cpu_clock_en),
    .watchdog_clock_en(watchdog_clock_en), .periph_clock_en(periph_clock_en),
    .time_base_clock_en(time_base_clock_en), .cpu_state_hold(cpu_state_hold), .held_pc(held_pc),
    .vector_request(vector_request), .time_base_vector(time_base_vector),
    .system_clock_reset(system_clock_reset), .high_osc_enable(high_osc_enable),
    .low_osc_enable(low_osc_enable), .system_clock_select(system_clock_select));

  smc_cpu_model u_smc_cpu_model (.ref_clk(ref_clk), .wake_cmd(wake_cmd), .irq_request(irq_request),
    .low_clock_pin(low_clock_pin), .tb_source_pins(tb_source_pins));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (vector_request === 1'b1) vec_cnt++;
    if (time_base_vector === 1'b1) tbv_cnt++;
  end

  task automatic end_sim;
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // Handshakes are judged at the falling edge, where they equal what the next rising edge samples
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    while (!b_t) begin
      @(negedge ref_clk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t  = s_axi_wvalid & s_axi_wready;
      b_t  = s_axi_bvalid & s_axi_bready;
      r    = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    while (!r_t) begin
      @(negedge ref_clk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t  = s_axi_rvalid & s_axi_rready;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic t_reset_values;
    logic [31:0] d;
    logic [1:0]  r;
    axr(SMC_STANDBY_CLOCK_CONTROL_OFS, d, r);
    `CHK(d[7:0], SMC_SCC_RESET)
    axr(SMC_STATUS_OFS, d, r);
    `CHK(d[18:16], SMC_RUN)
    `CHK(r, SMC_RESP_OKAY)
    `CHK(high_osc_enable, 1'b1)
    axr(8'h40, d, r);
    `CHK(r, SMC_RESP_SLVERR)
    `CHK(d, 32'h0)
    axw(8'h40, 32'h0000_0010, r);
    `CHK(r, SMC_RESP_SLVERR)
  endtask : t_reset_values

  task automatic t_cpu_halt(input logic master_interrupt_enable, input logic [7:0] scc, input logic [2:0] st, input logic [15:0] pc);
    logic [31:0] d;
    logic [1:0]  r;
    int          v0;
    v0 = vec_cnt;
    axw(SMC_INT_CONTROL_OFS, {31'h0, master_interrupt_enable}, r);
    entry_pc <= pc;
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, {24'h0, scc | 8'h10}, r);
    repeat (4) @(posedge ref_clk);
    `CHK(cpu_clock_en, 1'b0)
    `CHK(watchdog_clock_en, 1'b0)
    `CHK(periph_clock_en, 1'b1)
    `CHK(cpu_state_hold, 1'b1)
    `CHK(held_pc, pc + SMC_PC_STEP)
    axr(SMC_STATUS_OFS, d, r);
    `CHK(d[18:16], SMC_CPU_HALT)
    wake_cmd <= 1'b1;
    for (int i = 0; i < 200 && cpu_clock_en !== 1'b1; i++) @(posedge ref_clk);
    wake_cmd <= 1'b0;
    `CHK(cpu_clock_en, 1'b1)
    repeat (6) @(posedge ref_clk);
    `CHK(vec_cnt - v0, master_interrupt_enable ? 1 : 0)
    axr(SMC_STANDBY_CLOCK_CONTROL_OFS, d, r);
    `CHK(d[7:0], scc)
    axr(SMC_STATUS_OFS, d, r);
    `CHK(d[18:16], st)
  endtask : t_cpu_halt

  // Slow source selections keep the block halted long enough to read it back
  task automatic t_deep(input logic [7:0] tbc, input logic [31:0] ictl, input int exp_vec);
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    t0 = tbv_cnt;
    axw(SMC_TIME_BASE_CONTROL_OFS, {24'h0, tbc}, r);
    axw(SMC_INT_CONTROL_OFS, ictl, r);
    // Peripheral requests stay quiet while the timing generator is halted
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h84, r);
    repeat (3) @(posedge ref_clk);
    `CHK(periph_clock_en, 1'b0)
    `CHK(time_base_clock_en, 1'b1)
    `CHK(cpu_state_hold, 1'b1)
    axr(SMC_STATUS_OFS, d, r);
    `CHK(d[18:16], SMC_DEEP_HALT)
    axr(SMC_INT_CONTROL_OFS, d, r);
    `CHK(d[SMC_IL6_BIT], tbc[SMC_TBEN_BIT])
    for (int i = 0; i < 2500 && periph_clock_en !== 1'b1; i++) @(posedge ref_clk);
    `CHK(periph_clock_en, 1'b1)
    repeat (6) @(posedge ref_clk);
    `CHK(tbv_cnt - t0, exp_vec)
    axr(SMC_STANDBY_CLOCK_CONTROL_OFS, d, r);
    `CHK(d[7:0], 8'h80)
  endtask : t_deep

  task automatic t_both_bits;
    logic [1:0] r;
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h94, r);
    `CHK(r, SMC_RESP_OKAY)
    repeat (4) @(posedge ref_clk);
    `CHK(cpu_clock_en, 1'b1)
    `CHK(periph_clock_en, 1'b1)
  endtask : t_both_bits

  task automatic t_slow;
    logic [1:0] r;
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'he0, r);
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h60, r);
    repeat (2) @(posedge ref_clk);
    `CHK({system_clock_select, high_osc_enable, low_osc_enable}, 3'b101)
    `CHK(system_clock_reset, 1'b0)
    t_cpu_halt(1'b0, 8'h60, SMC_SLOW, 16'hfffe);
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h20, r);
    repeat (2) @(posedge ref_clk);
    `CHK(system_clock_reset, 1'b1)
  endtask : t_slow

  task automatic t_pin_reset_in_halt;
    logic [1:0] r;
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h90, r);
    repeat (4) @(posedge ref_clk);
    `CHK(cpu_clock_en, 1'b0)
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h00, r);
    repeat (2) @(posedge ref_clk);
    `CHK(system_clock_reset, 1'b1)
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK({cpu_clock_en, system_clock_reset, high_osc_enable}, 3'b101)
    t_reset_values();
  endtask : t_pin_reset_in_halt

  task automatic t_watchdog;
    logic [31:0] d;
    logic [1:0]  r;
    watchdog_irq <= 1'b1;
    @(posedge ref_clk);
    watchdog_irq <= 1'b0;
    axw(SMC_STANDBY_CLOCK_CONTROL_OFS, 32'h90, r);
    repeat (8) @(posedge ref_clk);
    `CHK(cpu_clock_en, 1'b1)
    axr(SMC_INT_CONTROL_OFS, d, r);
    `CHK(d[SMC_WD_PEND_BIT], 1'b1)
  endtask : t_watchdog

  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_cpu_halt(1'b0, 8'h80, SMC_RUN, 16'h1234);
    t_cpu_halt(1'b1, 8'h80, SMC_RUN, 16'hfffe);
    t_deep(8'h87, 32'h3, 1);
    t_deep(8'h07, 32'h3, 0);
    t_deep(8'h86, 32'h2, 0);
    t_both_bits();
    t_slow();
    t_pin_reset_in_halt();
    t_watchdog();
    end_sim();
  end
endmodule : smc_standby_mode_control_tb_top
